/* bench/host_uart_model.sv */
// Host UART on the shared single-wire line
`timescale 1ns/1ns
`default_nettype none
module host_uart_model #(
   parameter int BT = 32               // Host cycles per bit
) (
   input  wire logic core_clk,
   input  wire logic serial_tx_out,
   input  wire logic serial_tx_oe_n,
   output wire logic serial_powerdown_pin
);
   logic hd = 1'b1;                    // Host drive, idles high
   // Device owns the line while it replies
   assign serial_powerdown_pin = serial_tx_oe_n ? hd : serial_tx_out;
   task automatic send(input logic [7:0] b);
      for (int i = 0; i < 10; i++) begin
         hd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
         repeat (BT) @(posedge core_clk);
      end
   endtask
   task automatic recv(output logic [7:0] b, output logic ok);
      int n;
      n = 0;
      while (serial_powerdown_pin !== 1'b0 && n < 4000) begin
         @(posedge core_clk);
         n++;
      end
      repeat (BT / 2) @(posedge core_clk);
      for (int i = 0; i < 9; i++) begin
         repeat (BT) @(posedge core_clk);
         if (i < 8) b[i] = serial_powerdown_pin;
      end
      ok = (n < 4000) && (serial_powerdown_pin === 1'b1);
   endtask
endmodule // host_uart_model
`default_nettype wire

/* bench/stepper_port_checker_assertions.sv */
// Checker of the configuration port's pin-level behaviour
`timescale 1ns/1ns
`default_nettype none
module stepper_port_checker (
   input wire logic       core_clk,
   input wire logic       rst_n,
   input wire logic       drive_enable_n,
   input wire logic       power_stage_on,
   input wire logic       driver_error,
   input wire logic       fault_output,
   input wire logic       serial_tx_out,
   input wire logic       serial_tx_oe_n,
   input wire logic       step_out,
   input wire logic [3:0] microstep_log2
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ==========
   // Drive and fault
   a_drive_needs_en: assert property (power_stage_on |-> !drive_enable_n)
      else $error("drive on, enable off");
   a_en_high_off: assert property (drive_enable_n |-> !power_stage_on)
      else $error("drive on, enable high");
   a_fault_set: assert property (driver_error |=> fault_output)
      else $error("fault not set");
   a_fault_clear: assert property (drive_enable_n && !driver_error |=> !fault_output)
      else $error("fault not cleared");
   // ==========
   // Reply characters, steps and resolution range
   a_tx_start: assert property ($fell(serial_tx_oe_n) |-> ##[0:2] !serial_tx_out)
      else $error("no start bit");
   a_tx_stop: assert property ($rose(serial_tx_oe_n) |-> $past(serial_tx_out))
      else $error("no stop bit");
   a_step_width: assert property ($rose(step_out) |=> step_out [*3] ##1 !step_out)
      else $error("step pulse width");
   a_res_range: assert property (microstep_log2 <= 4'h8)
      else $error("resolution range");
   cover property ($fell(serial_tx_oe_n));
   cover property ($rose(step_out));
   cover property ($rose(fault_output));
endmodule // stepper_port_checker
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench of the stepper configuration port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam logic [7:0]  SLAVE = 8'h00;     // Node address
   localparam logic [15:0] PIN_RES = 16'h4213; // log2 by pin code
   logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, serial_powerdown_pin, serial_tx_out, serial_tx_oe_n;
   logic drive_enable_n = 1'b0, resolution_sel_0 = 1'b0, resolution_sel_1 = 1'b0;
   logic step_in = 1'b0, dir_in = 1'b0, driver_error = 1'b0;
   logic fault_output, index_output, power_stage_on, standstill_reduce, step_out, dir_out;
   logic [3:0] microstep_log2;
   int n_mismatch = 0, checked = 0;
   stepper_config_port #(.SLAVE_ADDR(SLAVE)) stepper_config_port_i (.core_clk, .rst_n,
      .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .serial_powerdown_pin, .serial_tx_out, .serial_tx_oe_n, .drive_enable_n,
      .resolution_sel_0, .resolution_sel_1, .step_in, .dir_in, .driver_error,
      .fault_output, .index_output, .power_stage_on, .standstill_reduce,
      .microstep_log2, .step_out, .dir_out);
   host_uart_model host_uart_model_i (.core_clk, .serial_tx_out, .serial_tx_oe_n,
      .serial_powerdown_pin);
   initial forever #5 core_clk = ~core_clk;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   function automatic logic [7:0] crc8(input logic [7:0] q[$]);
      logic [7:0] c, b;
      c = 8'h00;
      foreach (q[k]) begin
         b = q[k];
         for (int i = 0; i < 8; i++) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ b[0]) ? 8'h07 : 8'h00);
            b = b >> 1;
         end
      end
      return c;
   endfunction
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [32:0] r);
      @(posedge core_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      r = {pslverr, prdata};
      {psel, penable} <= 2'b00;
   endtask
   // Frame with optional write data; bad flips CRC bits
   task automatic frame(input logic [7:0] a, r, input logic [31:0] d, input logic [7:0] bad);
      logic [7:0] q[$];
      q = {8'h05, a, r};
      if (r[7]) q = {q, d[31:24], d[23:16], d[15:8], d[7:0]};
      q.push_back(crc8(q) ^ bad);
      foreach (q[k]) host_uart_model_i.send(q[k]);
   endtask
   task automatic reply(input logic [7:0] r, input logic [31:0] d);
      logic [7:0] q[$], b;
      logic ok;
      q = {8'h05, 8'hFF, r, d[31:24], d[23:16], d[15:8], d[7:0]};
      q.push_back(crc8(q));
      foreach (q[k]) begin
         host_uart_model_i.recv(b, ok);
         chk("reply byte", {1'b1, q[k]}, {ok, b});
      end
      // Let the device release the line first
      repeat (64) @(posedge core_clk);
   endtask
   task automatic tally_and_finish;
      if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #900000;
      n_mismatch++;
      tally_and_finish;
   end
   initial begin
      logic [32:0] r;
      logic [31:0] v, seed;
      int n;
      seed = 32'hD08DE8EB;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         {resolution_sel_1, resolution_sel_0} <= i[1:0];
         @(posedge core_clk);
         #1 chk("pin res", PIN_RES[i*4 +: 4], microstep_log2);
      end
      chk("standstill pin", 32'h0, standstill_reduce);
      chk("index", 32'h1, index_output);
      apb(1'b0, 8'h00, 32'h0, r);
      chk("port idle", 32'h0, r[0]);
      apb(1'b0, 8'h04, 32'h0, r);
      chk("ctrl reset", 32'h1, r[31:0]);
      apb(1'b1, 8'h0C, 32'h5, r);
      chk("unmapped", 32'h1, r[32]);
      driver_error <= 1'b1;
      @(posedge core_clk);
      driver_error <= 1'b0;
      @(posedge core_clk);
      #1 chk("fault", 32'h1, fault_output);
      drive_enable_n <= 1'b1;
      @(posedge core_clk);
      #1 chk("off", 32'h0, {fault_output, power_stage_on});
      drive_enable_n <= 1'b0;
      frame(SLAVE, 8'h82, 32'h8, 8'h01);
      apb(1'b0, 8'h08, 32'h0, r);
      chk("crc errors", 32'h1, r[31:0]);
      frame(SLAVE, 8'h80, 32'h1, 8'h00);
      apb(1'b0, 8'h00, 32'h0, r);
      chk("port active", 32'h1, r[0]);
      chk("res kept", 32'h4, microstep_log2);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         v = (i == 0) ? 32'h8 : (i == 1) ? 32'h0 : seed % 9;
         frame(SLAVE, 8'h82, v, 8'h00);
         chk("port res", v, microstep_log2);
         frame(SLAVE, 8'h02, 32'h0, 8'h00);
         reply(8'h02, v);
      end
      frame(SLAVE + 8'h01, 8'h82, (v + 32'h1) % 9, 8'h00);
      chk("other node", v, microstep_log2);
      // Velocity is write-only; a serial read of it replies zero
      frame(SLAVE, 8'h83, 32'h00F00000, 8'h00);
      n = 0;
      while (step_out !== 1'b1 && n < 64) begin
         @(posedge core_clk);
         n++;
      end
      chk("generator", 32'h3, {step_out, dir_out});
      frame(SLAVE, 8'h03, 32'h0, 8'h00);
      reply(8'h03, 32'h0);
      frame(SLAVE, 8'h80, 32'hF, 8'h00);
      chk("soft off", 32'h1, {power_stage_on, standstill_reduce});
      tally_and_finish;
   end
endmodule // tb_top
bind stepper_config_port stepper_port_checker chk_i (.core_clk, .rst_n, .drive_enable_n,
   .power_stage_on, .driver_error, .fault_output, .serial_tx_out, .serial_tx_oe_n,
   .step_out, .microstep_log2);
`default_nettype wire

/* core/serial_autobaud_rx.v */
// Receiver for 8N1 characters that learns the bit time from a start bit
`timescale 1ns/1ns
`default_nettype none
`include "stepper_port_defines.vh"
module serial_autobaud_rx (
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire        rxd,        // Line level
   input  wire        learn,      // Measure this start bit
   output reg  [7:0]  rx_byte,    // Received character
   output reg         rx_valid,   // One-cycle strobe
   output reg  [15:0] bit_time    // Learned cycles per bit
);
   localparam S_IDLE  = 2'h0;
   localparam S_START = 2'h1;
   localparam S_DATA  = 2'h2;
   localparam S_STOP  = 2'h3;
   reg [1:0]  state;              // Receiver state
   reg [15:0] cnt;                // Cycle counter in bit
   reg [3:0]  nbit;               // Data bits taken
   reg [7:0]  shift;              // Data shift register
   reg        learning;           // Current start bit is measured
   // ==========================================================
   // Character receiver
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state    <= S_IDLE;
         cnt      <= 16'h0000;
         nbit     <= 4'h0;
         shift    <= 8'h00;
         learning <= 1'b0;
         rx_byte  <= 8'h00;
         rx_valid <= 1'b0;
         bit_time <= `DEFAULT_BIT_CYC;
      end else begin
         rx_valid <= 1'b0;
         case (state)
            // Wait for falling edge
            S_IDLE: begin
               cnt <= 16'h0000;
               nbit <= 4'h0;
               if (!rxd) begin
                  state    <= S_START;
                  learning <= learn;
               end
            end
            // Measure or check the start bit
            S_START: begin
               cnt <= cnt + 16'h0001;
               if (learning) begin
                  if (rxd) begin
                     if (cnt < `MIN_BIT_CYC) begin
                        state <= S_IDLE;
                     end else begin
                        // Count ends one short of the low time
                        bit_time <= cnt + 16'h0001;
                        cnt      <= cnt >> 1;
                        state    <= S_DATA;
                     end
                  end
               end else if (cnt == (bit_time >> 1)) begin
                  cnt   <= 16'h0000;
                  state <= rxd ? S_IDLE : S_DATA;
               end
            end
            // Sample data bits mid-bit, LSB first
            S_DATA: begin
               if (cnt >= bit_time - 16'h0001) begin
                  cnt   <= 16'h0000;
                  shift <= {rxd, shift[7:1]};
                  nbit  <= nbit + 4'h1;
                  if (nbit == 4'h7) begin
                     state <= S_STOP;
                  end
               end else begin
                  cnt <= cnt + 16'h0001;
               end
            end
            // Stop bit must be high
            S_STOP: begin
               if (cnt >= bit_time - 16'h0001) begin
                  state    <= S_IDLE;
                  rx_byte  <= shift;
                  rx_valid <= rxd;
               end else begin
                  cnt <= cnt + 16'h0001;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule // serial_autobaud_rx
`default_nettype wire

/* core/serial_reply_tx.v */
// Transmitter for 8N1 reply characters on the shared line
`timescale 1ns/1ns
`default_nettype none
module serial_reply_tx (
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire [15:0] bit_time,   // Cycles per bit
   input  wire [7:0]  tx_byte,    // Character to send
   input  wire        tx_start,   // Start strobe
   output wire        tx_busy,    // Character in progress
   output reg         txd,        // Line level driven
   output reg         tx_oe_n     // Low while driving
);
   reg [9:0]  frame;              // Stop, data, start
   reg [3:0]  left;               // Bits still to send
   reg [15:0] cnt;                // Cycle counter in bit
   assign tx_busy = (left != 4'h0);
   // ==========================================================
   // Bit shifter
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         frame   <= 10'h3FF;
         left    <= 4'h0;
         cnt     <= 16'h0000;
         txd     <= 1'b1;
         tx_oe_n <= 1'b1;
      end else if (tx_start && !tx_busy) begin
         // Load and drive the start bit
         frame   <= {1'b1, tx_byte, 1'b0};
         left    <= 4'hA;
         cnt     <= 16'h0000;
         txd     <= 1'b0;
         tx_oe_n <= 1'b0;
      end else if (tx_busy) begin
         if (cnt >= bit_time - 16'h0001) begin
            cnt   <= 16'h0000;
            frame <= {1'b1, frame[9:1]};
            left  <= left - 4'h1;
            txd   <= (left == 4'h1) ? 1'b1 : frame[1];
            // Release the line after the stop bit
            tx_oe_n <= (left == 4'h1);
         end else begin
            cnt <= cnt + 16'h0001;
         end
      end
   end
endmodule // serial_reply_tx
`default_nettype wire

/* core/stepper_config_port.v */
// Single-wire register port, pin configuration and step logic of a stepper driver
`timescale 1ns/1ns
`default_nettype none
`include "stepper_port_defines.vh"
module stepper_config_port #(
   parameter [7:0] SLAVE_ADDR = 8'h00     // Fixed node address
) (
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire [7:0]  paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        serial_powerdown_pin,   // Shared line, input side
   output wire        serial_tx_out,          // Shared line, driven level
   output wire        serial_tx_oe_n,         // Low while driving the line
   input  wire        drive_enable_n,
   input  wire        resolution_sel_0,
   input  wire        resolution_sel_1,
   input  wire        step_in,
   input  wire        dir_in,
   input  wire        driver_error,
   output reg         fault_output,
   output reg         index_output,
   output wire        power_stage_on,
   output wire        standstill_reduce,
   output wire [3:0]  microstep_log2,
   output reg         step_out,
   output reg         dir_out
);
   localparam F_RECV = 2'h0;
   localparam F_GAP  = 2'h1;
   localparam F_SEND = 2'h2;
   // ==========================================================
   // CRC over one byte, used on receive and reply
   function [7:0] crc_step;
      input [7:0] crc;
      input [7:0] data;
      integer i;
      reg [7:0] c;
      begin
         c = crc;
         for (i = 0; i < 8; i = i + 1) begin
            if (c[7] ^ data[i]) begin
               c = {c[6:0], 1'b0} ^ `CRC_POLY;
            end else begin
               c = {c[6:0], 1'b0};
            end
         end
         crc_step = c;
      end
   endfunction
   // ==========================================================
   // State declarations
   reg  [1:0]  fstate;          // Frame state
   reg  [3:0]  idx;             // Byte index in frame
   reg  [7:0]  crc;             // Running CRC
   reg  [7:0]  addr_b;          // Address byte
   reg  [7:0]  reg_b;           // Register byte
   reg  [31:0] data_b;          // Data bytes
   reg  [15:0] tick_cnt;        // Bit tick counter
   reg  [7:0]  bits_idle;       // Bit times without a byte
   reg  [7:0]  out_bytes [0:7]; // Reply frame
   reg  [3:0]  out_idx;         // Reply byte index
   reg         port_active;     // Port woke up
   reg  [3:0]  gen_reg;         // General control bits
   reg  [3:0]  res_reg;         // Resolution code
   reg  [23:0] velocity;        // Signed generator velocity
   reg         reply_en;        // APB: bidirectional mode
   reg  [7:0]  crc_errors;      // APB: frames dropped on bad CRC
   reg  [23:0] vel_acc;         // Step generator phase
   reg  [9:0]  ustep;           // Microstep position
   reg         step_d;          // Step input delayed
   reg  [1:0]  step_hold;       // Step pulse stretcher
   wire [7:0]  rx_byte;
   wire        rx_valid;
   wire [15:0] bit_time;
   wire        tx_busy;
   wire        tx_start;
   wire        bit_tick;
   wire [7:0]  crc_next;
   wire        is_write;
   wire [3:0]  pin_log2;
   wire [23:0] vel_abs;
   wire [24:0] vel_sum;
   wire        step_evt;
   wire        step_dir;
   wire [9:0]  ustep_inc;
   reg  [31:0] read_value;
   // ==========================================================
   // Character receiver and transmitter
   serial_autobaud_rx u_rx (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .rxd      (serial_powerdown_pin | !serial_tx_oe_n),  // Own reply is not received
      .learn    (idx == 4'h0),
      .rx_byte  (rx_byte),
      .rx_valid (rx_valid),
      .bit_time (bit_time)
   );
   serial_reply_tx u_tx (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .bit_time (bit_time),
      .tx_byte  (out_bytes[out_idx[2:0]]),
      .tx_start (tx_start),
      .tx_busy  (tx_busy),
      .txd      (serial_tx_out),
      .tx_oe_n  (serial_tx_oe_n)
   );
   assign bit_tick = (tick_cnt >= bit_time - 16'h0001);
   assign crc_next = crc_step(crc, rx_byte);
   assign is_write = reg_b[`WRITE_FLAG_BIT];
   assign tx_start = (fstate == F_SEND) && !tx_busy;
   // ==========================================================
   // Value returned for a serial read
   always @* begin
      read_value = 32'h0000_0000;
      case (reg_b[6:0])
         `SREG_GENERAL:    read_value = {28'h0000000, gen_reg};
         `SREG_STATUS:     read_value = {24'h000000, microstep_log2, 1'b0,
                                         power_stage_on, fault_output, port_active};
         `SREG_RESOLUTION: read_value = {28'h0000000, res_reg};
         default:          read_value = 32'h0000_0000;
      endcase
   end
   // ==========================================================
   // Datagram decoder and reply sequencer
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fstate      <= F_RECV;
         idx         <= 4'h0;
         crc         <= 8'h00;
         addr_b      <= 8'h00;
         reg_b       <= 8'h00;
         data_b      <= 32'h0000_0000;
         tick_cnt    <= 16'h0000;
         bits_idle   <= 8'h00;
         out_idx     <= 4'h0;
         port_active <= 1'b0;
         gen_reg     <= `GEN_RESET;
         res_reg     <= `RES_RESET;
         velocity    <= 24'h000000;
         crc_errors  <= 8'h00;
      end else begin
         tick_cnt <= bit_tick ? 16'h0000 : tick_cnt + 16'h0001;
         case (fstate)
            // Collect frame bytes
            F_RECV: begin
               if (rx_valid) begin
                  bits_idle <= 8'h00;
                  idx       <= idx + 4'h1;
                  crc       <= crc_next;
                  case (idx)
                     4'h0: begin
                        if (rx_byte != `SYNC_BYTE) begin
                           idx <= 4'h0;
                        end
                        crc <= crc_step(8'h00, rx_byte);
                     end
                     4'h1: addr_b <= rx_byte;
                     4'h2: reg_b  <= rx_byte;
                     default: data_b <= {rx_byte, data_b[31:8]};
                  endcase
                  if ((idx == `READ_FRAME_LEN - 4'h1 && !is_write) ||
                      (idx == `WRITE_FRAME_LEN - 4'h1)) begin
                     idx <= 4'h0;
                     if (rx_byte != crc) begin
                        if (crc_errors != 8'hFF) begin
                           crc_errors <= crc_errors + 8'h01;
                        end
                     end else if (addr_b == SLAVE_ADDR) begin
                        port_active <= 1'b1;
                        if (is_write) begin
                           case (reg_b[6:0])
                              `SREG_GENERAL:    gen_reg  <= data_b[27:24];
                              `SREG_RESOLUTION: res_reg  <= data_b[27:24];
                              `SREG_VELOCITY:   velocity <= rx_byte_guard(data_b);
                              default:          gen_reg  <= gen_reg;
                           endcase
                        end else if (reply_en) begin
                           fstate    <= F_GAP;
                           bits_idle <= 8'h00;
                        end
                     end
                  end
               end else if (idx != 4'h0 && bit_tick) begin
                  // Abandon a stalled frame
                  bits_idle <= bits_idle + 8'h01;
                  if (bits_idle == `IDLE_RESET_BITS) begin
                     idx       <= 4'h0;
                     bits_idle <= 8'h00;
                  end
               end
            end
            // Turnaround gap while the reply is built
            F_GAP: begin
               if (bit_tick) begin
                  bits_idle <= bits_idle + 8'h01;
               end
               if (bits_idle == `REPLY_GAP_BITS) begin
                  fstate  <= F_SEND;
                  out_idx <= 4'h0;
               end
            end
            // Send eight reply bytes
            F_SEND: begin
               if (tx_start) begin
                  out_idx <= out_idx + 4'h1;
                  if (out_idx == 4'h7) begin
                     fstate    <= F_RECV;
                     bits_idle <= 8'h00;
                  end
               end
            end
            default: fstate <= F_RECV;
         endcase
      end
   end
   // Reply frame with CRC appended
   // reply carries CRC
   always @(posedge core_clk) begin
      if (fstate == F_GAP) begin
         out_bytes[0] <= `SYNC_BYTE;
         out_bytes[1] <= `REPLY_ADDR;
         out_bytes[2] <= {1'b0, reg_b[6:0]};
         out_bytes[3] <= read_value[31:24];
         out_bytes[4] <= read_value[23:16];
         out_bytes[5] <= read_value[15:8];
         out_bytes[6] <= read_value[7:0];
         out_bytes[7] <= crc_step(crc_step(crc_step(crc_step(crc_step(crc_step(
                         crc_step(8'h00, `SYNC_BYTE), `REPLY_ADDR), {1'b0, reg_b[6:0]}),
                         read_value[31:24]), read_value[23:16]), read_value[15:8]),
                         read_value[7:0]);
      end
   end
   // Velocity bytes arrive most significant first
   function [23:0] rx_byte_guard;
      input [31:0] d;
      begin
         rx_byte_guard = {d[15:8], d[23:16], d[31:24]};
      end
   endfunction
   // ==========================================================
   // Pin or port configuration
   // pins: 1/8, 1/2, 1/4, 1/16
   assign pin_log2 = ({resolution_sel_1, resolution_sel_0} == 2'b00) ? 4'h3 :
                     ({resolution_sel_1, resolution_sel_0} == 2'b01) ? 4'h1 :
                     ({resolution_sel_1, resolution_sel_0} == 2'b10) ? 4'h2 : 4'h4;
   assign microstep_log2 = (port_active && gen_reg[`GEN_RES_BY_REG]) ?
                           ((res_reg > `RES_FULLSTEP_LOG2) ? `RES_FULLSTEP_LOG2 : res_reg) :
                           pin_log2;
   assign standstill_reduce = (port_active && gen_reg[`GEN_PDN_BY_REG]) ?
                              gen_reg[`GEN_STANDSTILL_RED] : !serial_powerdown_pin;
   assign power_stage_on = !drive_enable_n && !gen_reg[`GEN_SOFT_DISABLE];
   // ==========================================================
   // Step generator and microstep position
   assign vel_abs   = velocity[23] ? (~velocity + 24'h000001) : velocity;
   assign vel_sum   = {1'b0, vel_acc} + {1'b0, vel_abs};
   assign step_evt  = (velocity != 24'h000000) ? vel_sum[24] : (step_in && !step_d);
   assign step_dir  = (velocity != 24'h000000) ? velocity[23] : dir_in;
   assign ustep_inc = 10'h100 >> (4'h8 - microstep_log2);
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         vel_acc      <= 24'h000000;
         ustep        <= 10'h000;
         step_d       <= 1'b0;
         step_hold    <= 2'h0;
         step_out     <= 1'b0;
         dir_out      <= 1'b0;
         index_output <= 1'b0;
         fault_output <= 1'b0;
      end else begin
         step_d  <= step_in;
         vel_acc <= (velocity != 24'h000000) ? vel_sum[23:0] : 24'h000000;
         dir_out <= step_dir;
         if (step_evt) begin
            ustep     <= step_dir ? ustep - ustep_inc : ustep + ustep_inc;
            step_hold <= 2'h3;
         end else if (step_hold != 2'h0) begin
            step_hold <= step_hold - 2'h1;
         end
         step_out <= step_evt || (step_hold != 2'h0);
         index_output <= (ustep < ustep_inc);
         if (driver_error) begin
            fault_output <= 1'b1;
         end else if (drive_enable_n) begin
            fault_output <= 1'b0;
         end
      end
   end
   // ==========================================================
   // APB slave, zero wait states
   assign pready  = 1'b1;
   assign pslverr = psel && penable && (paddr != `APB_STATUS) &&
                    (paddr != `APB_CTRL) && (paddr != `APB_CRC_ERRORS);
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reply_en <= `CTRL_RESET;
         prdata   <= 32'h0000_0000;
      end else begin
         if (psel && penable && pwrite && paddr == `APB_CTRL) begin
            reply_en <= pwdata[`CTRL_REPLY_EN];
         end
         if (psel && !penable && !pwrite) begin
            case (paddr)
               `APB_STATUS:     prdata <= {24'h000000, microstep_log2, standstill_reduce,
                                           power_stage_on, fault_output, port_active};
               `APB_CTRL:       prdata <= {31'h00000000, reply_en};
               `APB_CRC_ERRORS: prdata <= {24'h000000, crc_errors};
               default:         prdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule // stepper_config_port
`default_nettype wire

/* core/stepper_port_defines.vh */
// Constants for the stepper single-wire configuration port
`ifndef STEPPER_PORT_DEFINES_VH
`define STEPPER_PORT_DEFINES_VH
// ==========================================================
// Clock and serial timing
`define CLK_HZ              100000000
`define SLOW_BAUD           9600
`define DEFAULT_BIT_CYC     16'h28B0  // CLK_HZ / SLOW_BAUD, at register width
`define MIN_BIT_CYC         16'h0010
`define IDLE_RESET_BITS     8'h0C
`define REPLY_GAP_BITS      8'h08
// ==========================================================
// Datagram layout
`define SYNC_BYTE           8'h05
`define REPLY_ADDR          8'hFF
`define WRITE_FLAG_BIT      7
`define WRITE_FRAME_LEN     4'h8
`define READ_FRAME_LEN      4'h4
`define CRC_POLY            8'h07
// ==========================================================
// Serial register indices
`define SREG_GENERAL        7'h00
`define SREG_STATUS         7'h01
`define SREG_RESOLUTION     7'h02
`define SREG_VELOCITY       7'h03
// General register fields
`define GEN_RES_BY_REG      0
`define GEN_PDN_BY_REG      1
`define GEN_STANDSTILL_RED  2
`define GEN_SOFT_DISABLE    3
`define GEN_RESET           4'h0
`define RES_RESET           4'h4
`define RES_FULLSTEP_LOG2   4'h8
// ==========================================================
// APB byte offsets
`define APB_STATUS          8'h00
`define APB_CTRL            8'h04
`define APB_CRC_ERRORS      8'h08
`define CTRL_REPLY_EN       0
`define CTRL_RESET          1'b1
`endif
